// ### inc/async_mem_pkg.sv
package async_mem_pkg;

   // ---------------------------------------------------------------
   // field widths of the per-space timing controls, and the phase counter's width
   // ---------------------------------------------------------------
   localparam int SETUP_W  = 4;
   localparam int STROBE_W = 6;
   localparam int HOLD_W   = 3;
   localparam int COUNT_W  = 6;

   // ---------------------------------------------------------------
   // instance defaults
   // ---------------------------------------------------------------
   localparam int WIDE_DATA_W   = 64;
   localparam int NARROW_DATA_W = 16;
   localparam int ADDR_W_DEF    = 20;
   localparam int NUM_CS_DEF    = 4;
   localparam int FIFO_DEPTH    = 16;

   // least count loaded for any phase, and the counter's last value
   localparam logic [COUNT_W-1:0] COUNT_MIN  = 6'h01;
   localparam logic [COUNT_W-1:0] COUNT_LAST = 6'h01;

   // ---------------------------------------------------------------
   // one chip-select space's control word
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [SETUP_W-1:0]  write_setup_cycles;
      logic [STROBE_W-1:0] write_strobe_cycles;
      logic [HOLD_W-1:0]   write_hold_cycles;
      logic [SETUP_W-1:0]  read_setup_cycles;
      logic [STROBE_W-1:0] read_strobe_cycles;
      logic [HOLD_W-1:0]   read_hold_cycles;
   } space_timing_type;

   // sequencer phases
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } phase_type;

endpackage

// ### src/request_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module request_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0]   fill_q;
   wire              push;
   wire              pop;

   // ---------------------------------------------------------------
   // handshakes
   // ---------------------------------------------------------------
   assign in_ready_o  = (fill_q != (PTR_W+1)'(DEPTH));
   assign out_valid_o = (fill_q != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem_q[rd_ptr_q];

   // storage, written at the write index
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         mem_q[wr_ptr_q] <= in_data_i;
   end

   // pointers and fill level
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q   <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         fill_q <= fill_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end

endmodule
`default_nettype wire

// ### src/async_memory_strobe_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module async_memory_strobe_sequencer
   import async_mem_pkg::*;
#(
   parameter int DATA_W = async_mem_pkg::WIDE_DATA_W,
   parameter int ADDR_W = async_mem_pkg::ADDR_W_DEF,
   parameter int NUM_CS = async_mem_pkg::NUM_CS_DEF
) (
   input  wire logic                                clk_sys_i,
   input  wire logic                                reset_i,
   // per-space timing controls
   input  wire async_mem_pkg::space_timing_type     space_timing_i [NUM_CS],
   // request stream
   input  wire logic                                req_valid_i,
   output logic                                     req_ready_o,
   input  wire logic                                req_write_i,
   input  wire logic [$clog2(NUM_CS)-1:0]           req_space_i,
   input  wire logic [ADDR_W-1:0]                   req_addr_i,
   input  wire logic [DATA_W/8-1:0]                 req_byte_en_i,
   input  wire logic [DATA_W-1:0]                   req_wdata_i,
   // read answer
   output logic                                     rd_valid_o,
   output logic      [DATA_W-1:0]                   rd_data_o,
   output logic                                     busy_o,
   // memory pins
   output logic                                     ifc_clock_out_o,
   output logic      [NUM_CS-1:0]                   chip_select_n_o,
   output logic      [DATA_W/8-1:0]                 byte_en_n_o,
   output logic      [ADDR_W-1:0]                   mem_addr_o,
   output logic                                     output_enable_n_o,
   output logic                                     read_strobe_n_o,
   output logic                                     write_strobe_n_o,
   input  wire logic [DATA_W-1:0]                   mem_data_bus_i,
   output logic      [DATA_W-1:0]                   mem_data_bus_o,
   output logic                                     mem_data_bus_oe_o,
   input  wire logic                                mem_ready_in_i
);
   import async_mem_pkg::*;

   localparam int SPACE_W = $clog2(NUM_CS);
   localparam int BE_W    = DATA_W / 8;
   localparam int REQ_W   = 1 + SPACE_W + ADDR_W + BE_W + DATA_W;

   // ---------------------------------------------------------------
   // request buffer
   // ---------------------------------------------------------------
   wire [REQ_W-1:0] fifo_in;
   wire [REQ_W-1:0] fifo_out;
   wire             fifo_valid;
   wire             fifo_pop;

   assign fifo_in = {req_write_i, req_space_i, req_addr_i, req_byte_en_i, req_wdata_i};

   request_fifo #(
      .WIDTH (REQ_W),
      .DEPTH (FIFO_DEPTH)
   ) u_req_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .in_valid_i  (req_valid_i),
      .in_ready_o  (req_ready_o),
      .in_data_i   (fifo_in),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out)
   );

   // head-of-queue fields
   wire                  head_write = fifo_out[REQ_W-1];
   wire [SPACE_W-1:0]    head_space = fifo_out[REQ_W-2 -: SPACE_W];
   wire [ADDR_W-1:0]     head_addr  = fifo_out[DATA_W+BE_W +: ADDR_W];
   wire [BE_W-1:0]       head_be    = fifo_out[DATA_W +: BE_W];
   wire [DATA_W-1:0]     head_wdata = fifo_out[DATA_W-1:0];

   // ---------------------------------------------------------------
   // interface output clock and ready synchroniser
   // ---------------------------------------------------------------
   logic clk_div_q;
   logic ready_meta_q;
   logic ready_sync_q;
   wire  tick;

   // tick marks the system edge on which the output clock rises
   assign tick            = ~clk_div_q;
   assign ifc_clock_out_o = clk_div_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         clk_div_q    <= 1'b0;
         ready_meta_q <= 1'b0;
         ready_sync_q <= 1'b0;
      end
      else
      begin
         clk_div_q    <= ~clk_div_q;
         ready_meta_q <= mem_ready_in_i;
         ready_sync_q <= ready_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // access state and latched access fields
   // ---------------------------------------------------------------
   phase_type            phase_q, phase_d;
   logic [COUNT_W-1:0]   cnt_q, cnt_d;
   logic                 is_write_q;
   logic [SPACE_W-1:0]   space_q;
   space_timing_type     tim_q;

   // phase lengths of the running access, never below one cycle
   wire [COUNT_W-1:0] setup_len  = is_write_q ?
      COUNT_W'(tim_q.write_setup_cycles) : COUNT_W'(tim_q.read_setup_cycles);
   wire [COUNT_W-1:0] strobe_len = is_write_q ?
      COUNT_W'(tim_q.write_strobe_cycles) : COUNT_W'(tim_q.read_strobe_cycles);
   wire [COUNT_W-1:0] hold_len   = is_write_q ?
      COUNT_W'(tim_q.write_hold_cycles) : COUNT_W'(tim_q.read_hold_cycles);
   wire [COUNT_W-1:0] setup_ld   = (setup_len  == '0) ? COUNT_MIN : setup_len;
   wire [COUNT_W-1:0] strobe_ld  = (strobe_len == '0) ? COUNT_MIN : strobe_len;
   wire [COUNT_W-1:0] hold_ld    = (hold_len   == '0) ? COUNT_MIN : hold_len;

   wire cnt_done   = (cnt_q == COUNT_LAST);
   wire start      = tick & (phase_q == ST_IDLE) & fifo_valid;
   wire strobe_end = tick & (phase_q == ST_STROBE) & cnt_done & ready_sync_q;

   assign fifo_pop = start;
   assign busy_o   = (phase_q != ST_IDLE);

   // next phase, advancing only on output clock rises
   always_comb
   begin
      phase_d = phase_q;
      cnt_d   = cnt_q;
      if (tick)
      begin
         case (phase_q)
            ST_IDLE:
            begin
               if (fifo_valid)
               begin
                  phase_d = ST_SETUP;
                  cnt_d   = '0;                              // loaded once timing latched
               end
            end
            ST_SETUP:
            begin
               if (cnt_q == '0)
                  cnt_d = setup_ld;
               else if (cnt_done)
               begin
                  phase_d = ST_STROBE;
                  cnt_d   = strobe_ld;
               end
               else
                  cnt_d = cnt_q - 1'b1;
            end
            ST_STROBE:
            begin
               if (!cnt_done)
                  cnt_d = cnt_q - 1'b1;
               else if (ready_sync_q)
               begin
                  phase_d = ST_HOLD;
                  cnt_d   = hold_ld;
               end
            end
            ST_HOLD:
            begin
               if (cnt_done)
                  phase_d = ST_IDLE;
               else
                  cnt_d = cnt_q - 1'b1;
            end
            default:
            begin
               phase_d = ST_IDLE;
               cnt_d   = '0;
            end
         endcase
      end
   end

   // the extra setup tick that loads the count is counted as a setup cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         phase_q <= ST_IDLE;
         cnt_q   <= '0;
      end
      else
      begin
         phase_q <= phase_d;
         cnt_q   <= cnt_d;
      end
   end

   // latch the access and its space's timing when it starts
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         is_write_q <= 1'b0;
         space_q    <= '0;
         tim_q      <= '0;
      end
      else if (start)
      begin
         is_write_q <= head_write;
         space_q    <= head_space;
         tim_q      <= space_timing_i[head_space];
      end
   end

   // ---------------------------------------------------------------
   // pin drive, registered from the next phase
   // ---------------------------------------------------------------
   wire next_active = (phase_d != ST_IDLE);
   wire next_strobe = (phase_d == ST_STROBE);
   wire next_write  = start ? head_write : is_write_q;
   wire [SPACE_W-1:0] next_space = start ? head_space : space_q;

   wire  [NUM_CS-1:0] cs_dec;

   // one-hot select decode, one per space
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CS; gi++)
      begin : g_cs
         assign cs_dec[gi] = next_active & (next_space == SPACE_W'(gi));
      end
   endgenerate

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         chip_select_n_o   <= '1;
         byte_en_n_o       <= '1;
         mem_addr_o        <= '0;
         output_enable_n_o <= 1'b1;
         read_strobe_n_o   <= 1'b1;
         write_strobe_n_o  <= 1'b1;
         mem_data_bus_o    <= '0;
         mem_data_bus_oe_o <= 1'b0;
      end
      else
      begin
         chip_select_n_o   <= ~cs_dec;
         output_enable_n_o <= ~(next_active & ~next_write);
         read_strobe_n_o   <= ~(next_strobe & ~next_write);
         write_strobe_n_o  <= ~(next_strobe & next_write);
         mem_data_bus_oe_o <= next_active & next_write;
         if (start)
         begin
            byte_en_n_o    <= ~head_be;
            mem_addr_o     <= head_addr;
            mem_data_bus_o <= head_wdata;
         end
         else if (!next_active)
            byte_en_n_o    <= '1;
      end
   end

   // ---------------------------------------------------------------
   // read capture as the read strobe rises
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         rd_valid_o <= 1'b0;
         rd_data_o  <= '0;
      end
      else
      begin
         rd_valid_o <= strobe_end & ~is_write_q;
         if (strobe_end & ~is_write_q)
            rd_data_o <= mem_data_bus_i;
      end
   end

endmodule
`default_nettype wire

// ### tb/async_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module async_mem_model #(
   parameter int W = 64
) (
   input  wire logic           clk_sys_i,
   input  wire logic           sel_n_i,
   input  wire logic [W/8-1:0] byte_en_n_i,
   input  wire logic [3:0]     addr_i,
   input  wire logic           output_enable_n_i,
   input  wire logic           write_strobe_n_i,
   input  wire logic [W-1:0]   wdata_i,
   input  wire logic           wdata_oe_i,
   input  wire logic           stall_i,
   output logic      [W-1:0]   rdata_o,
   output logic                ready_o
);
   logic [W-1:0] mem [16];
   logic [W-1:0] last_q = '0;
   logic         drive;

   initial
      for (int i = 0; i < 16; i++)
         mem[i] = '0;
   // data drives once selected and enabled, well before the strobe rises
   assign drive   = !sel_n_i && !output_enable_n_i;
   assign rdata_o = drive ? mem[addr_i] : ~last_q;
   // ready follows the stall request, whose levels last many interface cycles
   assign ready_o = !stall_i;
   always @(posedge clk_sys_i)
      if (drive)
         last_q <= mem[addr_i];
   // write lands on the strobe's rising edge, byte lanes gated
   always @(posedge write_strobe_n_i)
      if (!sel_n_i && wdata_oe_i === 1'b1)
         for (int i = 0; i < W/8; i++)
            if (!byte_en_n_i[i])
               mem[addr_i][i*8 +: 8] <= wdata_i[i*8 +: 8];
endmodule

`default_nettype wire

// ### tb/async_mem_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module async_mem_checker #(
   parameter int NUM_CS = 4
) (
   input  wire logic              clk_sys_i,
   input  wire logic              reset_i,
   input  wire logic              ifc_clock_out_o,
   input  wire logic [NUM_CS-1:0] chip_select_n_o,
   input  wire logic              output_enable_n_o,
   input  wire logic              read_strobe_n_o,
   input  wire logic              write_strobe_n_o,
   input  wire logic              mem_data_bus_oe_o,
   input  wire logic              mem_ready_in_i,
   input  wire logic              rd_valid_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // pin function, setup, hold and ready relations
   ifc_clk_div_a: assert property (
      !$past(reset_i, 2) |-> ifc_clock_out_o != $past(ifc_clock_out_o))
      else $error("interface clock not toggling");
   strobe_excl_a: assert property (read_strobe_n_o || write_strobe_n_o)
      else $error("both strobes low");
   cs_onehot_a: assert property ($onehot0(~chip_select_n_o))
      else $error("more than one select low");
   rd_enable_a: assert property (
      !read_strobe_n_o |-> !output_enable_n_o && !(&chip_select_n_o))
      else $error("read strobe without select");
   wr_enable_a: assert property (
      !write_strobe_n_o |-> mem_data_bus_oe_o && output_enable_n_o)
      else $error("write strobe without data drive");
   rd_setup_a: assert property (
      $fell(read_strobe_n_o) |-> $past(output_enable_n_o, 4) == 1'b0)
      else $error("read setup too short");
   wr_setup_a: assert property (
      $fell(write_strobe_n_o) |-> $past(mem_data_bus_oe_o, 4))
      else $error("write setup too short");
   rd_hold_a: assert property ($rose(read_strobe_n_o) |-> !output_enable_n_o [*2])
      else $error("read hold too short");
   wr_hold_a: assert property (
      $rose(write_strobe_n_o) |-> (mem_data_bus_oe_o && !(&chip_select_n_o)) [*2])
      else $error("write hold too short");
   strobe_width_a: assert property (
      $fell(read_strobe_n_o) || $fell(write_strobe_n_o) |=>
      !(read_strobe_n_o && write_strobe_n_o))
      else $error("strobe shorter than one interface cycle");
   ready_stretch_a: assert property (
      !mem_ready_in_i [*6] |=> !$rose(read_strobe_n_o) && !$rose(write_strobe_n_o))
      else $error("strobe ended while not ready");
   // read data is registered on the edge that raises the strobe
   rd_capture_a: assert property ($rose(read_strobe_n_o) |-> rd_valid_o)
      else $error("read data not returned");
   cover property ($rose(read_strobe_n_o));
   cover property ($rose(write_strobe_n_o));
   cover property (!mem_ready_in_i [*6] ##1 !read_strobe_n_o);
endmodule

bind async_memory_strobe_sequencer async_mem_checker #(.NUM_CS(NUM_CS)) chk (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ifc_clock_out_o(ifc_clock_out_o),
   .chip_select_n_o(chip_select_n_o), .output_enable_n_o(output_enable_n_o),
   .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
   .mem_data_bus_oe_o(mem_data_bus_oe_o), .mem_ready_in_i(mem_ready_in_i),
   .rd_valid_o(rd_valid_o));

`default_nettype wire

// ### tb/async_memory_strobe_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module async_memory_strobe_sequencer_tb;
   import async_mem_pkg::*;
   logic             clk_sys_i = 1'b0;
   logic             reset_i = 1'b1;
   space_timing_type tim [4];
   logic             rv = 1'b0, rw = 1'b0, stall = 1'b0;
   logic [1:0]       rs = 2'h0;
   logic [19:0]      ra = 20'h00000;
   logic [7:0]       rb = 8'h00;
   logic [63:0]      wd = 64'h0, shadow [16];
   logic [31:0]      seed = 32'h40D3;
   wire logic        req_ready_o, rd_valid_o, busy_o, ifc_clk, roe, rdn, wrn, doe, rdy;
   wire logic [3:0]  csn;
   wire logic [7:0]  ben;
   wire logic [19:0] addr;
   wire logic [63:0] rd_data, mq, wq, md;
   wire logic        act = csn != 4'hF;
   wire logic        stb = rdn & wrn;
   logic             pact = 1'b0, pstb = 1'b1;
   int               errors = 0, total_checks = 0, cyc = 0, t0, t1, t2, slow = 0, n;
   int               exp_q [$];
   logic [63:0]      rd_q [$];
   logic [63:0]      e_rd;
   int               t_rel = 0, ks;
   // narrow port instance, run with the same requests as the wide one
   wire logic        nrdy_req, nrd_valid, nbusy, nifc, nroe, nrdn, nwrn, ndoe, nrdy;
   wire logic [3:0]  ncsn;
   wire logic [1:0]  nben;
   wire logic [19:0] naddr;
   wire logic [15:0] nrd_data, nmq, nwq, nmd;
   wire logic [49:0] wpins = {req_ready_o, busy_o, ifc_clk, csn, roe, rdn, wrn, doe,
                              rd_valid_o, addr, ben[1:0], wq[15:0]};
   wire logic [49:0] npins = {nrdy_req, nbusy, nifc, ncsn, nroe, nrdn, nwrn, ndoe,
                              nrd_valid, naddr, nben, nwq};

   async_memory_strobe_sequencer #(.DATA_W(64), .ADDR_W(20), .NUM_CS(4)) dut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .space_timing_i(tim),
      .req_valid_i(rv), .req_ready_o(req_ready_o), .req_write_i(rw), .req_space_i(rs),
      .req_addr_i(ra), .req_byte_en_i(rb), .req_wdata_i(wd), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data), .busy_o(busy_o), .ifc_clock_out_o(ifc_clk),
      .chip_select_n_o(csn), .byte_en_n_o(ben), .mem_addr_o(addr),
      .output_enable_n_o(roe), .read_strobe_n_o(rdn), .write_strobe_n_o(wrn),
      .mem_data_bus_i(md), .mem_data_bus_o(wq), .mem_data_bus_oe_o(doe),
      .mem_ready_in_i(rdy));
   async_mem_model #(.W(64)) mem (
      .clk_sys_i(clk_sys_i), .sel_n_i(&csn), .byte_en_n_i(ben), .addr_i(addr[3:0]),
      .output_enable_n_i(roe), .write_strobe_n_i(wrn), .wdata_i(wq), .wdata_oe_i(doe),
      .stall_i(stall), .rdata_o(mq), .ready_o(rdy));
   // shared data bus: whoever enables drives it
   assign md = doe ? wq : mq;
   async_memory_strobe_sequencer #(.DATA_W(16), .ADDR_W(20), .NUM_CS(4)) dut_narrow (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .space_timing_i(tim),
      .req_valid_i(rv), .req_ready_o(nrdy_req), .req_write_i(rw), .req_space_i(rs),
      .req_addr_i(ra), .req_byte_en_i(rb[1:0]), .req_wdata_i(wd[15:0]),
      .rd_valid_o(nrd_valid), .rd_data_o(nrd_data), .busy_o(nbusy),
      .ifc_clock_out_o(nifc), .chip_select_n_o(ncsn), .byte_en_n_o(nben),
      .mem_addr_o(naddr), .output_enable_n_o(nroe), .read_strobe_n_o(nrdn),
      .write_strobe_n_o(nwrn), .mem_data_bus_i(nmd), .mem_data_bus_o(nwq),
      .mem_data_bus_oe_o(ndoe), .mem_ready_in_i(nrdy));
   async_mem_model #(.W(16)) nmem (
      .clk_sys_i(clk_sys_i), .sel_n_i(&ncsn), .byte_en_n_i(nben), .addr_i(naddr[3:0]),
      .output_enable_n_i(nroe), .write_strobe_n_i(nwrn), .wdata_i(nwq), .wdata_oe_i(ndoe),
      .stall_i(stall), .rdata_o(nmq), .ready_o(nrdy));
   assign nmd = ndoe ? nwq : nmq;

   initial
      forever #2.5 clk_sys_i = ~clk_sys_i;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // system cycles of a phase; zero counts as one
   function automatic int ph(int v, int extra);
      return 2 * ((v == 0 ? 1 : v) + extra);
   endfunction
   function automatic logic [63:0] mrg(logic [63:0] o, n, logic [7:0] b);
      for (int i = 0; i < 8; i++)
         if (b[i])
            o[i*8 +: 8] = n[i*8 +: 8];
      return o;
   endfunction

   task automatic check_int(string nm, int g, int e);
      total_checks++;
      if (e < 0 ? g < -e : g != e)
      begin
         errors++;
         $display("unexpected %s exp %0d got %0d", nm, e, g);
      end
   endtask
   task automatic check_vec(string nm, logic [63:0] g, logic [63:0] e);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // expected phase lengths and read data of one accepted request
   task automatic note();
      space_timing_type t;
      int               k;
      t = tim[rs];
      exp_q.push_back(15 ^ (1 << rs));
      exp_q.push_back(rw ? ph(t.write_setup_cycles, 1) : ph(t.read_setup_cycles, 1));
      k = rw ? ph(t.write_strobe_cycles, 0) : ph(t.read_strobe_cycles, 0);
      exp_q.push_back(slow ? -(k + 40) : k);
      exp_q.push_back(rw ? ph(t.write_hold_cycles, 0) : ph(t.read_hold_cycles, 0));
      if (rw)
         shadow[ra[3:0]] = mrg(shadow[ra[3:0]], wd, rb);
      else
         rd_q.push_back(shadow[ra[3:0]]);
      slow = 0;
   endtask
   task automatic send(int f);
      logic [31:0] a;
      a = xs();
      rw = a[0];
      rs = a[2:1];
      ra = a[31:12];
      if (f >= 0)
      begin
         rw = f[0];
         rs = f[2:1];
      end
      rb = rw ? a[11:4] : 8'hFF;
      wd = {xs(), xs()};
      rv = 1'b1;
      while (req_ready_o !== 1'b1)
         @(negedge clk_sys_i);
      note();
      @(negedge clk_sys_i);
   endtask
   task automatic idle();
      rv = 1'b0;
      while (exp_q.size() != 0 || busy_o !== 1'b0)
         @(negedge clk_sys_i);
   endtask

   // pin monitor: measures setup, strobe and hold in system cycles
   always @(negedge clk_sys_i)
   begin
      cyc++;
      if (act && !pact)
         t0 = cyc;
      if (act && !pact)
         check_vec("selects", 64'(csn), 64'(exp_q.pop_front()));
      if (!stb && pstb)
         t1 = cyc;
      if (stb && !pstb)
         t2 = cyc;
      if (!act && pact)
      begin
         check_int("setup", t1 - t0, exp_q.pop_front());
         ks = exp_q.pop_front();
         check_int("strobe", t2 - t1, ks);
         // a stalled strobe ends a few cycles after ready returns
         if (ks < 0)
            check_int("stall release", int'(t2 - t_rel >= 2 && t2 - t_rel <= 6), 1);
         check_int("hold", cyc - t2, exp_q.pop_front());
      end
      if (rd_valid_o === 1'b1)
      begin
         e_rd = rd_q.pop_front();
         check_vec("read data", rd_data, e_rd);
         check_vec("narrow read data", 64'(nrd_data), 64'(e_rd[15:0]));
      end
      check_vec("narrow pins", 64'(npins), 64'(wpins));
      pact = act;
      pstb = stb;
   end

   initial
   begin
      #200000;
      errors++;
      results();
   end

   initial
   begin
      for (int i = 0; i < 16; i++)
         shadow[i] = '0;
      tim = '{'0, space_timing_type'(xs()), space_timing_type'(xs()), '1};
      repeat (5) @(negedge clk_sys_i);
      check_vec("idle pins", {ifc_clk, csn, roe, rdn, wrn, doe, ben, addr},
                {1'b0, 4'hF, 3'h7, 1'b0, 8'hFF, 20'h0});
      reset_i = 1'b0;
      for (int i = 0; i < 8; i++)
         send(i);
      repeat (24) send(-1);
      idle();
      $display("corner and random access test done");
      for (int i = 0; i < 4; i++)
         tim[i] = space_timing_type'(xs());
      stall = 1'b1;
      slow = 1;
      n = 0;
      while (req_ready_o === 1'b1 && n < 30)
      begin
         send(-1);
         n++;
      end
      rv = 1'b0;
      check_int("queued", n, FIFO_DEPTH + 1);
      // stall outlasts the longest programmed setup plus strobe
      repeat (200) @(negedge clk_sys_i);
      t_rel = cyc;
      stall = 1'b0;
      idle();
      $display("stall and fill test done");
      results();
   end
endmodule

`default_nettype wire
